// File: cca_defines.svh
// constants for the clear-channel alarm control block
// Summary of operation
// - Transmit control and receive registers repeat per port, same offset in each page.
// - Transmit AIS bit 0 passes normal data; 1 forces the outgoing stream to ones.
// - Transmit AIS is forced by the control bit OR the transmit-AIS input pin.
// - Manual downstream AIS bit 12 at 1 inserts AIS into downstream receive data.
// - Auto AIS disable bit 11 at 0 lets signal absence insert downstream AIS.
// - Live bit 8 reads 1 while the framer reports unframed all ones.
// - Live bit 0 follows the level of the signal-absent input pin.
// - Latched bit 8 sets on any change of the live unframed-all-ones bit.
// - Latched bit 0 sets on any change of the live signal-absent bit.
// - Latched unframed-all-ones bit with its enable set raises the interrupt.
// - Latched signal-absent bit with its enable set raises the interrupt.
`ifndef CCA_DEFINES_SVH
`define CCA_DEFINES_SVH

`define CCA_NUM_PORTS       4
`define CCA_ADR_W           11
`define CCA_PAGE_BIT        8
`define CCA_PORT_LSB        9
`define CCA_PORT_MSB        10

`define CCA_OFF_TX_CTRL     8'h18
`define CCA_OFF_RX_CTRL     8'h20
`define CCA_OFF_RX_LIVE     8'h24
`define CCA_OFF_RX_LATCHED  8'h28
`define CCA_OFF_RX_IRQ_EN   8'h2C

`define CCA_TX_AIS_BIT      0
`define CCA_MAN_AIS_BIT     12
`define CCA_AUTO_DIS_BIT    11
`define CCA_UA1_BIT         8
`define CCA_SA_BIT          0

`define CCA_REG_RESET       16'h0000

`endif

// File: cca_pkg.sv
// types shared by the clear-channel alarm control modules
package cca_pkg;

  typedef enum logic [2:0] {
    CCA_REG_NONE       = 3'h0,
    CCA_REG_TX_CTRL    = 3'h1,
    CCA_REG_RX_CTRL    = 3'h3,
    CCA_REG_RX_LIVE    = 3'h2,
    CCA_REG_RX_LATCHED = 3'h6,
    CCA_REG_RX_IRQ_EN  = 3'h7
  } cca_reg_t;

endpackage

// File: cca_path_if.sv
// per-port signals between the register core and the stream path
`timescale 1ns/1ns
interface cca_path_if;
  logic tx_line;
  logic tx_force;
  logic tx_out;
  logic rx_line;
  logic rx_force;
  logic rx_out;
  logic ais_active;

  modport ctl (
    output tx_line,
    output tx_force,
    output rx_line,
    output rx_force,
    input  tx_out,
    input  rx_out,
    input  ais_active
  );

  modport path (
    input  tx_line,
    input  tx_force,
    input  rx_line,
    input  rx_force,
    output tx_out,
    output rx_out,
    output ais_active
  );
endinterface

// File: cca_stream_path.sv
// per-port clear-channel stream path with AIS forcing
`timescale 1ns/1ns
module cca_stream_path (
  input wire logic clk,
  input wire logic rst,
  cca_path_if.path pif
);

  logic tx_out_q;
  logic rx_out_q;
  logic ais_q;

  // one register stage on both streams so force and data line up
  always_ff @(posedge clk) begin
    if (rst) begin
      tx_out_q <= 1'b0;
    end else begin
      tx_out_q <= pif.tx_force ? 1'b1 : pif.tx_line;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rx_out_q <= 1'b0;
      ais_q    <= 1'b0;
    end else begin
      rx_out_q <= pif.rx_force ? 1'b1 : pif.rx_line;
      ais_q    <= pif.rx_force;
    end
  end

  assign pif.tx_out     = tx_out_q;
  assign pif.rx_out     = rx_out_q;
  assign pif.ais_active = ais_q;

endmodule

// File: cca_top.sv
// clear-channel alarm control: register pages, status latching and AIS control
`timescale 1ns/1ns
`include "cca_defines.svh"
module cca_top (
  input  wire logic                       CORE_CLK,
  input  wire logic                       RST,
  input  wire logic [`CCA_ADR_W-1:0]      ADR_I,
  input  wire logic [31:0]                DAT_I,
  output logic      [31:0]                DAT_O,
  input  wire logic                       WE_I,
  input  wire logic [3:0]                 SEL_I,
  input  wire logic                       CYC_I,
  input  wire logic                       STB_I,
  output logic                            ACK_O,
  input  wire logic [`CCA_NUM_PORTS-1:0]  TX_DATA_IN,
  input  wire logic [`CCA_NUM_PORTS-1:0]  TX_AIS_PIN,
  output logic      [`CCA_NUM_PORTS-1:0]  TX_DATA_OUT,
  input  wire logic [`CCA_NUM_PORTS-1:0]  RX_DATA_IN,
  input  wire logic [`CCA_NUM_PORTS-1:0]  RX_UNFRAMED_ALL_ONES,
  input  wire logic [`CCA_NUM_PORTS-1:0]  SIGNAL_ABSENT_PIN,
  output logic      [`CCA_NUM_PORTS-1:0]  RX_DATA_OUT,
  output logic      [`CCA_NUM_PORTS-1:0]  DOWNSTREAM_AIS,
  output logic                            IRQ
);

  localparam int NP = `CCA_NUM_PORTS;

  logic          ack_q;
  logic [31:0]   dat_q;
  logic          irq_q;
  logic [NP-1:0] tx_ais_q;
  logic [NP-1:0] man_ais_q;
  logic [NP-1:0] auto_dis_q;
  logic [NP-1:0] ua1_live_q;
  logic [NP-1:0] sa_live_q;
  logic [NP-1:0] ua1_lat_q;
  logic [NP-1:0] sa_lat_q;
  logic [NP-1:0] ua1_ie_q;
  logic [NP-1:0] sa_ie_q;
  logic [NP-1:0] ua1_lat_d;
  logic [NP-1:0] sa_lat_d;

  logic              req;
  logic              take;
  logic              page_ok;
  logic [1:0]        port_sel;
  cca_pkg::cca_reg_t reg_sel;
  logic [15:0]       wmask;
  logic [15:0]       wbits;

  // register select from the low byte of the address within a port page
  function automatic cca_pkg::cca_reg_t reg_decode(input logic [7:0] off);
    cca_pkg::cca_reg_t r;
    r = cca_pkg::CCA_REG_NONE;
    unique case (off)
      `CCA_OFF_TX_CTRL:    r = cca_pkg::CCA_REG_TX_CTRL;
      `CCA_OFF_RX_CTRL:    r = cca_pkg::CCA_REG_RX_CTRL;
      `CCA_OFF_RX_LIVE:    r = cca_pkg::CCA_REG_RX_LIVE;
      `CCA_OFF_RX_LATCHED: r = cca_pkg::CCA_REG_RX_LATCHED;
      `CCA_OFF_RX_IRQ_EN:  r = cca_pkg::CCA_REG_RX_IRQ_EN;
      default:             r = cca_pkg::CCA_REG_NONE;
    endcase
    return r;
  endfunction

  // places one live/latched/enable pair into the status layout
  function automatic logic [15:0] status_word(input logic ua1, input logic sa);
    logic [15:0] w;
    w = `CCA_REG_RESET;
    w[`CCA_UA1_BIT] = ua1;
    w[`CCA_SA_BIT]  = sa;
    return w;
  endfunction

  // true when a write of this cycle targets register r of port p
  function automatic logic wr_hit(input cca_pkg::cca_reg_t r, input int p);
    return take && WE_I && page_ok && (reg_sel == r) && (port_sel == p[1:0]);
  endfunction

  assign req      = CYC_I & STB_I;
  // writes and latched clears act only at the edge that sees ack
  assign take     = req & ack_q;
  assign page_ok  = ADR_I[`CCA_PAGE_BIT];
  assign port_sel = ADR_I[`CCA_PORT_MSB:`CCA_PORT_LSB];
  assign reg_sel  = reg_decode({ADR_I[7:2], 2'b00});
  assign wmask    = {{8{SEL_I[1]}}, {8{SEL_I[0]}}};
  assign wbits    = DAT_I[15:0] & wmask;

  // one wait state per access, ack drops the cycle after it is given
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  // read data is captured as ack rises; unmapped offsets read zero
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      dat_q <= 32'h0000_0000;
    end else if (req && !ack_q) begin
      dat_q <= 32'h0000_0000;
      if (page_ok) begin
        unique case (reg_sel)
          cca_pkg::CCA_REG_TX_CTRL: begin
            dat_q[`CCA_TX_AIS_BIT] <= tx_ais_q[port_sel];
          end
          cca_pkg::CCA_REG_RX_CTRL: begin
            dat_q[`CCA_MAN_AIS_BIT]  <= man_ais_q[port_sel];
            dat_q[`CCA_AUTO_DIS_BIT] <= auto_dis_q[port_sel];
          end
          cca_pkg::CCA_REG_RX_LIVE: begin
            dat_q[15:0] <= status_word(ua1_live_q[port_sel], sa_live_q[port_sel]);
          end
          cca_pkg::CCA_REG_RX_LATCHED: begin
            dat_q[15:0] <= status_word(ua1_lat_q[port_sel], sa_lat_q[port_sel]);
          end
          cca_pkg::CCA_REG_RX_IRQ_EN: begin
            dat_q[15:0] <= status_word(ua1_ie_q[port_sel], sa_ie_q[port_sel]);
          end
          cca_pkg::CCA_REG_NONE: begin
            dat_q <= 32'h0000_0000;
          end
        endcase
      end
    end
  end

  assign ACK_O = ack_q;
  assign DAT_O = dat_q;

  // transmit control, one copy per port
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      tx_ais_q <= '0;
    end else begin
      for (int i = 0; i < NP; i++) begin
        if (wr_hit(cca_pkg::CCA_REG_TX_CTRL, i) && SEL_I[0]) begin
          tx_ais_q[i] <= DAT_I[`CCA_TX_AIS_BIT];
        end
      end
    end
  end

  // receive control; both bits live in byte lane 1
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      man_ais_q  <= '0;
      auto_dis_q <= '0;
    end else begin
      for (int i = 0; i < NP; i++) begin
        if (wr_hit(cca_pkg::CCA_REG_RX_CTRL, i) && SEL_I[1]) begin
          man_ais_q[i]  <= DAT_I[`CCA_MAN_AIS_BIT];
          auto_dis_q[i] <= DAT_I[`CCA_AUTO_DIS_BIT];
        end
      end
    end
  end

  // interrupt enables
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      ua1_ie_q <= '0;
      sa_ie_q  <= '0;
    end else begin
      for (int i = 0; i < NP; i++) begin
        if (wr_hit(cca_pkg::CCA_REG_RX_IRQ_EN, i)) begin
          if (SEL_I[1]) begin
            ua1_ie_q[i] <= DAT_I[`CCA_UA1_BIT];
          end
          if (SEL_I[0]) begin
            sa_ie_q[i] <= DAT_I[`CCA_SA_BIT];
          end
        end
      end
    end
  end

  // live status samples the framer flag and the pin every cycle
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      ua1_live_q <= '0;
      sa_live_q  <= '0;
    end else begin
      ua1_live_q <= RX_UNFRAMED_ALL_ONES;
      sa_live_q  <= SIGNAL_ABSENT_PIN;
    end
  end

  // a change is seen as the input differing from its live copy, so the
  // latched bit sets in the same edge as the live bit moves
  always_comb begin
    for (int i = 0; i < NP; i++) begin
      ua1_lat_d[i] = ua1_lat_q[i];
      sa_lat_d[i]  = sa_lat_q[i];
      if (wr_hit(cca_pkg::CCA_REG_RX_LATCHED, i)) begin
        ua1_lat_d[i] = ua1_lat_q[i] & ~wbits[`CCA_UA1_BIT];
        sa_lat_d[i]  = sa_lat_q[i] & ~wbits[`CCA_SA_BIT];
      end
      if (RX_UNFRAMED_ALL_ONES[i] != ua1_live_q[i]) begin
        ua1_lat_d[i] = 1'b1;
      end
      if (SIGNAL_ABSENT_PIN[i] != sa_live_q[i]) begin
        sa_lat_d[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      ua1_lat_q <= '0;
      sa_lat_q  <= '0;
    end else begin
      ua1_lat_q <= ua1_lat_d;
      sa_lat_q  <= sa_lat_d;
    end
  end

  // level interrupt, registered to keep the output glitch free
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |((ua1_lat_q & ua1_ie_q) | (sa_lat_q & sa_ie_q));
    end
  end

  assign IRQ = irq_q;

  for (genvar gi = 0; gi < NP; gi++) begin : g_port
    cca_path_if pif ();

    assign pif.tx_line  = TX_DATA_IN[gi];
    assign pif.tx_force = tx_ais_q[gi] | TX_AIS_PIN[gi];
    assign pif.rx_line  = RX_DATA_IN[gi];
    // pin used directly: insertion starts without waiting for the live copy
    assign pif.rx_force = man_ais_q[gi] | (~auto_dis_q[gi] & SIGNAL_ABSENT_PIN[gi]);

    cca_stream_path cca_stream_path_inst (
      .clk (CORE_CLK),
      .rst (RST),
      .pif (pif.path)
    );

    assign TX_DATA_OUT[gi]    = pif.tx_out;
    assign RX_DATA_OUT[gi]    = pif.rx_out;
    assign DOWNSTREAM_AIS[gi] = pif.ais_active;
  end

endmodule

// File: cca_top_sva.sv
// assertion checker for the clear-channel alarm control top
`timescale 1ns/1ns
`include "cca_defines.svh"
module cca_top_sva (
  input wire logic                      CORE_CLK,
  input wire logic                      RST,
  input wire logic                      CYC_I,
  input wire logic                      STB_I,
  input wire logic                      ACK_O,
  input wire logic [31:0]               DAT_O,
  input wire logic [`CCA_NUM_PORTS-1:0] TX_DATA_IN,
  input wire logic [`CCA_NUM_PORTS-1:0] TX_AIS_PIN,
  input wire logic [`CCA_NUM_PORTS-1:0] TX_DATA_OUT,
  input wire logic [`CCA_NUM_PORTS-1:0] RX_DATA_IN,
  input wire logic [`CCA_NUM_PORTS-1:0] RX_DATA_OUT,
  input wire logic [`CCA_NUM_PORTS-1:0] DOWNSTREAM_AIS,
  input wire logic                      IRQ
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  logic take;
  assign take = CYC_I && STB_I && !ACK_O;

  a_ack_after_take: assert property (take |=> ACK_O)
    else $error("request not acknowledged");
  a_ack_one_cycle: assert property (ACK_O |=> !ACK_O)
    else $error("ack longer than one cycle");
  a_ack_has_req: assert property (ACK_O |-> $past(take))
    else $error("ack without request");
  a_dat_hold: assert property (!take |=> $stable(DAT_O))
    else $error("read data moved without request");
  a_dat_upper_zero: assert property (DAT_O[31:16] == 16'h0000)
    else $error("upper read data not zero");
  // bits forced by TX_AIS_PIN, or already one on TX_DATA_IN, must come out as ones
  a_tx_force_or: assert property (!RST |=>
    ((TX_DATA_OUT & $past(TX_AIS_PIN | TX_DATA_IN)) == $past(TX_AIS_PIN | TX_DATA_IN)))
    else $error("transmit output lost a one");
  a_rx_ais_data: assert property (!RST |=>
    (RX_DATA_OUT == (DOWNSTREAM_AIS | $past(RX_DATA_IN))))
    else $error("receive output disagrees with ais flag");
  a_quiet_after_rst: assert property ($fell(RST) |->
    !ACK_O && !IRQ && DOWNSTREAM_AIS == 4'h0 && TX_DATA_OUT == 4'h0)
    else $error("outputs not cleared by reset");

  c_irq_rise: cover property ($rose(IRQ));
  c_ais_rise: cover property ($rose(DOWNSTREAM_AIS[0]));
  c_read_data: cover property (ACK_O && DAT_O != 32'h0000_0000);
endmodule

// File: testbench.sv
// self-checking bench for the clear-channel alarm control top
`timescale 1ns/1ns
module testbench;
  logic        CORE_CLK = 1'b0;
  logic        RST = 1'b1;
  logic        WE_I = 1'b0;
  logic        CYC_I = 1'b0;
  logic        STB_I = 1'b0;
  logic [10:0] ADR_I = 11'h000;
  logic [31:0] DAT_I = 32'h0000_0000;
  logic [3:0]  SEL_I = 4'h0;
  logic [3:0]  TX_DATA_IN = 4'h0;
  logic [3:0]  TX_AIS_PIN = 4'h0;
  logic [3:0]  RX_DATA_IN = 4'h0;
  logic [3:0]  RX_UNFRAMED_ALL_ONES = 4'h0;
  logic [3:0]  SIGNAL_ABSENT_PIN = 4'h0;
  logic [31:0] DAT_O;
  logic        ACK_O;
  logic        IRQ;
  logic [3:0]  TX_DATA_OUT;
  logic [3:0]  RX_DATA_OUT;
  logic [3:0]  DOWNSTREAM_AIS;
  logic [15:0] rd;
  logic [3:0]  wsel = 4'h3;
  int          mismatches = 0;
  int          n_checks = 0;

  always #5 CORE_CLK = ~CORE_CLK;

  cca_top cca_top_inst (.CORE_CLK, .RST, .ADR_I, .DAT_I, .DAT_O, .WE_I, .SEL_I, .CYC_I, .STB_I,
    .ACK_O, .TX_DATA_IN, .TX_AIS_PIN, .TX_DATA_OUT, .RX_DATA_IN, .RX_UNFRAMED_ALL_ONES,
    .SIGNAL_ABSENT_PIN, .RX_DATA_OUT, .DOWNSTREAM_AIS, .IRQ);

  task summarize;
    if (mismatches == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [10:0] ra(input int p, input logic [7:0] off);
    return {p[1:0], 1'b1, off};
  endfunction

  // waits for ack without assuming its latency
  task wb(input logic [10:0] a, input logic w, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge CORE_CLK);
    ADR_I <= a;
    WE_I <= w;
    DAT_I <= {16'h0000, d};
    SEL_I <= wsel;
    CYC_I <= 1'b1;
    STB_I <= 1'b1;
    do begin
      @(posedge CORE_CLK);
      n++;
    end while (ACK_O !== 1'b1 && n < 20);
    rd = DAT_O[15:0];
    CYC_I <= 1'b0;
    STB_I <= 1'b0;
    WE_I <= 1'b0;
    if (n >= 20) mismatches++;
  endtask

  task rdchk(input logic [10:0] a, input logic [15:0] exp);
    wb(a, 1'b0, 16'h0000);
    chk(rd, exp);
  endtask

  task settle;
    repeat (3) @(posedge CORE_CLK);
    #1;
  endtask

  task t_reset_map;
    logic [39:0] offs;
    offs = 40'h18_20_24_28_2C;
    for (int p = 0; p < 4; p++) begin
      for (int i = 0; i < 5; i++) rdchk(ra(p, offs[8*i +: 8]), 16'h0000);
    end
    // 0x1A shares the word at 0x18, so the reserved word at 0x1C stands in
    wb(ra(1, 8'h1C), 1'b1, 16'hFFFF);
    rdchk(ra(1, 8'h1C), 16'h0000);
    rdchk(ra(1, 8'h18), 16'h0000);
    wb(11'h018, 1'b1, 16'hFFFF);
    rdchk(ra(0, 8'h18), 16'h0000);
    wb(ra(3, 8'h18), 1'b1, 16'hFFFF);
    rdchk(ra(3, 8'h18), 16'h0001);
    rdchk(ra(2, 8'h18), 16'h0000);
    wb(ra(3, 8'h20), 1'b1, 16'hFFFF);
    rdchk(ra(3, 8'h20), 16'h1800);
    wb(ra(3, 8'h18), 1'b1, 16'h0000);
    wb(ra(3, 8'h20), 1'b1, 16'h0000);
  endtask

  task t_tx;
    @(posedge CORE_CLK);
    TX_DATA_IN <= 4'h5;
    settle;
    chk(16'(TX_DATA_OUT), 16'h0005);
    wb(ra(1, 8'h18), 1'b1, 16'h0001);
    settle;
    chk(16'(TX_DATA_OUT), 16'h0007);
    @(posedge CORE_CLK);
    TX_AIS_PIN <= 4'h8;
    settle;
    chk(16'(TX_DATA_OUT), 16'h000F);
    wb(ra(1, 8'h18), 1'b1, 16'h0000);
    settle;
    chk(16'(TX_DATA_OUT), 16'h000D);
  endtask

  task t_rx;
    @(posedge CORE_CLK);
    RX_DATA_IN <= 4'h2;
    SIGNAL_ABSENT_PIN <= 4'h1;
    settle;
    chk(16'(DOWNSTREAM_AIS), 16'h0001);
    chk(16'(RX_DATA_OUT), 16'h0003);
    wb(ra(0, 8'h20), 1'b1, 16'h0800);
    settle;
    chk(16'(RX_DATA_OUT), 16'h0002);
    wb(ra(2, 8'h20), 1'b1, 16'h1000);
    settle;
    chk(16'(DOWNSTREAM_AIS), 16'h0004);
    wb(ra(2, 8'h20), 1'b1, 16'h0000);
    settle;
    chk(16'(DOWNSTREAM_AIS), 16'h0000);
    chk(16'(IRQ), 16'h0000);
  endtask

  task t_status;
    @(posedge CORE_CLK);
    SIGNAL_ABSENT_PIN <= 4'h4;
    settle;
    rdchk(ra(2, 8'h24), 16'h0001);
    rdchk(ra(2, 8'h28), 16'h0001);
    @(posedge CORE_CLK);
    RX_UNFRAMED_ALL_ONES <= 4'h4;
    settle;
    rdchk(ra(2, 8'h24), 16'h0101);
    rdchk(ra(2, 8'h28), 16'h0101);
    chk(16'(IRQ), 16'h0000);
    wb(ra(2, 8'h2C), 1'b1, 16'h0100);
    settle;
    chk(16'(IRQ), 16'h0001);
    wb(ra(2, 8'h28), 1'b1, 16'h0000);
    rdchk(ra(2, 8'h28), 16'h0101);
    wb(ra(2, 8'h28), 1'b1, 16'h0100);
    settle;
    chk(16'(IRQ), 16'h0000);
    wb(ra(2, 8'h2C), 1'b1, 16'h0001);
    settle;
    chk(16'(IRQ), 16'h0001);
    wb(ra(2, 8'h28), 1'b1, 16'h0001);
    @(posedge CORE_CLK);
    SIGNAL_ABSENT_PIN <= 4'h0;
    RX_UNFRAMED_ALL_ONES <= 4'h0;
    settle;
    rdchk(ra(2, 8'h24), 16'h0000);
    rdchk(ra(2, 8'h28), 16'h0101);
    chk(16'(IRQ), 16'h0001);
    wb(ra(2, 8'h28), 1'b1, 16'hFFFF);
    settle;
    chk(16'(IRQ), 16'h0000);
  endtask

  // pin toggles until the ack edge, so the last change meets the clear
  task t_clear_race;
    @(posedge CORE_CLK);
    ADR_I <= ra(1, 8'h28);
    WE_I <= 1'b1;
    DAT_I <= 32'h0000_0001;
    SEL_I <= 4'h3;
    CYC_I <= 1'b1;
    STB_I <= 1'b1;
    do begin
      @(posedge CORE_CLK);
      if (ACK_O !== 1'b1) SIGNAL_ABSENT_PIN[1] <= ~SIGNAL_ABSENT_PIN[1];
    end while (ACK_O !== 1'b1);
    CYC_I <= 1'b0;
    STB_I <= 1'b0;
    WE_I <= 1'b0;
    rdchk(ra(1, 8'h28), 16'h0001);
    wb(ra(1, 8'h28), 1'b1, 16'h0001);
    rdchk(ra(1, 8'h28), 16'h0000);
  endtask

  // a write whose byte lane is off leaves that byte alone
  task t_lanes;
    wsel = 4'h1;
    wb(ra(1, 8'h20), 1'b1, 16'h1800);
    rdchk(ra(1, 8'h20), 16'h0000);
    wsel = 4'h2;
    wb(ra(1, 8'h18), 1'b1, 16'h0001);
    rdchk(ra(1, 8'h18), 16'h0000);
    wb(ra(1, 8'h2C), 1'b1, 16'h0101);
    rdchk(ra(1, 8'h2C), 16'h0100);
    wsel = 4'h3;
  endtask

  initial begin
    repeat (20) @(posedge CORE_CLK);
    RST <= 1'b0;
    t_reset_map;
    t_tx;
    t_rx;
    t_status;
    t_clear_race;
    t_lanes;
    summarize;
  end

  // the sequence needs a few hundred cycles at most
  initial begin
    #100000;
    mismatches++;
    summarize;
  end
endmodule

bind cca_top cca_top_sva cca_top_sva_inst (.CORE_CLK(CORE_CLK), .RST(RST), .CYC_I(CYC_I),
  .STB_I(STB_I), .ACK_O(ACK_O), .DAT_O(DAT_O), .TX_DATA_IN(TX_DATA_IN), .TX_AIS_PIN(TX_AIS_PIN),
  .TX_DATA_OUT(TX_DATA_OUT), .RX_DATA_IN(RX_DATA_IN), .RX_DATA_OUT(RX_DATA_OUT),
  .DOWNSTREAM_AIS(DOWNSTREAM_AIS), .IRQ(IRQ));
